// File: pkg/ccp_pkg.sv
// Package for the converter configuration port: word layout, reset values, states.
// Assumes a 50 MHz system clock sampling the serial link pins.
package ccp_pkg;
    localparam int CCP_WORD_WIDTH = 9;
    localparam int CCP_START_POS = 8;
    localparam int CCP_SIGN_POS = 7;
    localparam int CCP_WIDE_POS = 6;
    localparam int CCP_SLEEP_POS = 5;
    localparam int CCP_CODE_POS = 2;
    localparam int CCP_LAST_COUNT = 9;
    localparam logic [8:0] CCP_WORD_RESET = 9'h000;
    localparam logic [3:0] CCP_COUNT_RESET = 4'h0;
    localparam int CCP_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        CCP_IDLE = 2'b00,
        CCP_SHIFT = 2'b01,
        CCP_DONE = 2'b11
    } ccp_state_type;

    typedef enum logic [1:0] {
        CCP_RANGE_UNI5 = 2'b00,
        CCP_RANGE_UNI10 = 2'b01,
        CCP_RANGE_BIP5 = 2'b10,
        CCP_RANGE_BIP10 = 2'b11
    } ccp_range_type;
endpackage : ccp_pkg

// File: pkg/ccp_link_if.sv
// Interface carrying synchronised link levels from the synchroniser to the port logic.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface ccp_link_if;
    logic selectN;
    logic serialIn;
    logic serialClock;
    modport sync (output selectN, output serialIn, output serialClock);
    modport core (input selectN, input serialIn, input serialClock);
endinterface : ccp_link_if

// File: hdl/ccp_sync.sv
// Two-flop synchroniser for the three configuration link pins.
// Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
module ccp_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Raw pins
    input wire logic cfgSelectPin_n,
    input wire logic cfgSerialInPin,
    input wire logic cfgSerialClockPin,
    // Synchronised levels
    ccp_link_if.sync link
);
    import ccp_pkg::*;
    logic [2:0] stage1_q;
    logic [2:0] stage2_q;

    // Select idles high so a reset does not look like a frame
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stage1_q <= 3'h4;
            stage2_q <= 3'h4;
        end else begin
            stage1_q <= {cfgSelectPin_n, cfgSerialInPin, cfgSerialClockPin};
            stage2_q <= stage1_q;
        end
    end

    assign link.selectN = stage2_q[2];
    assign link.serialIn = stage2_q[1];
    assign link.serialClock = stage2_q[0];
endmodule : ccp_sync

// File: hdl/converter_config_port.sv
// Configuration logic: pin straps or serial write-only configuration word.
// Assumes link pins are asynchronous and sampled by the 50 MHz clock.
`timescale 1ns/1ps
module converter_config_port (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Mode straps
    input wire logic interface_select,
    input wire logic config_source_select,
    input wire logic clock_edge_invert,
    // Hardware configuration pins
    input wire logic pinBipolar,
    input wire logic wide_span_select,
    input wire logic output_code_format,
    input wire logic sleep_request,
    // Serial configuration link
    input wire logic cfg_select_n,
    input wire logic cfg_serial_in,
    input wire logic cfg_serial_clock,
    // Effective configuration
    output ccp_pkg::ccp_range_type inputRange,
    output logic straightBinary,
    output logic powerDown,
    output logic wordCommitted
);
    import ccp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    ccp_link_if link ();
    logic [2:0] strapStage1_q;
    logic [2:0] strapStage2_q;
    logic [3:0] hwStage1_q;
    logic [3:0] hwStage2_q;

    ccp_sync u_sync (
        .clock(clock),
        .arst_n(arst_n),
        .cfgSelectPin_n(cfg_select_n),
        .cfgSerialInPin(cfg_serial_in),
        .cfgSerialClockPin(cfg_serial_clock),
        .link(link)
    );

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            strapStage1_q <= 3'h0;
            strapStage2_q <= 3'h0;
            hwStage1_q <= 4'h0;
            hwStage2_q <= 4'h0;
        end else begin
            strapStage1_q <= {interface_select, config_source_select, clock_edge_invert};
            strapStage2_q <= strapStage1_q;
            hwStage1_q <= {pinBipolar, wide_span_select, sleep_request, output_code_format};
            hwStage2_q <= hwStage1_q;
        end
    end

    wire serialMode = strapStage2_q[2];
    wire hwSource = strapStage2_q[1];
    wire invertEdge = strapStage2_q[0];
    wire useSoftware = serialMode && !hwSource;
    wire useHardware = !useSoftware;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection on the synchronised link clock
    logic serialClockPrev_q;
    logic selectPrev_q;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            serialClockPrev_q <= 1'b0;
            selectPrev_q <= 1'b1;
        end else begin
            serialClockPrev_q <= link.serialClock;
            selectPrev_q <= link.selectN;
        end
    end

    // Each link clock half period needs over one clock; 40 MHz is out of reach
    wire riseEdge = link.serialClock && !serialClockPrev_q;
    wire fallEdge = !link.serialClock && serialClockPrev_q;
    // Inverted clock samples on the falling edge
    wire sampleEdge = invertEdge ? fallEdge : riseEdge;
    wire framed = !link.selectN && useSoftware;
    wire selectRise = link.selectN && !selectPrev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Shift state machine
    ccp_state_type state_q, state_d;
    logic [8:0] shift_q, shift_d;
    logic [3:0] count_q, count_d;
    logic [8:0] word_q, word_d;
    logic committed_q, committed_d;

    wire [8:0] shifted = {shift_q[7:0], link.serialIn};
    wire lastEdge = sampleEdge && (count_q == 4'(CCP_LAST_COUNT - 1));
    // Keep reserved bits of the active word unchanged
    wire [8:0] mergedWord = {shifted[CCP_START_POS], shifted[7:5], word_q[4:3],
                             shifted[CCP_CODE_POS], word_q[1:0]};

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        count_d = count_q;
        word_d = word_q;
        committed_d = 1'b0;
        unique case (state_q)
            CCP_IDLE: begin
                // Frame starts on the first sampling edge that finds the data line high
                if (framed && sampleEdge && link.serialIn) begin
                    shift_d = {8'h00, link.serialIn};
                    count_d = 4'h1;
                    state_d = CCP_SHIFT;
                end
            end
            CCP_SHIFT: begin
                if (!framed) begin
                    count_d = CCP_COUNT_RESET;
                    state_d = CCP_IDLE;
                end else if (lastEdge) begin
                    word_d = mergedWord;
                    committed_d = 1'b1;
                    count_d = CCP_COUNT_RESET;
                    state_d = CCP_DONE;
                end else if (sampleEdge) begin
                    shift_d = shifted;
                    count_d = count_q + 4'h1;
                end
            end
            CCP_DONE: begin
                // Extra edges ignored until select releases
                if (!framed) begin
                    state_d = CCP_IDLE;
                end
            end
            default: begin
                state_d = CCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= CCP_IDLE;
            shift_q <= CCP_WORD_RESET;
            count_q <= CCP_COUNT_RESET;
            word_q <= CCP_WORD_RESET;
            committed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            count_q <= count_d;
            word_q <= word_d;
            committed_q <= committed_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output selection; software word or live pins
    wire [1:0] swRange = word_q[CCP_SIGN_POS:CCP_WIDE_POS];
    wire [1:0] hwRange = hwStage2_q[3:2];
    wire [1:0] rangeSel = useHardware ? hwRange : swRange;
    wire codeSel = useHardware ? hwStage2_q[0] : word_q[CCP_CODE_POS];
    wire sleepSel = useHardware ? hwStage2_q[1] : word_q[CCP_SLEEP_POS];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            inputRange <= CCP_RANGE_UNI5;
            straightBinary <= 1'b0;
            powerDown <= 1'b0;
        end else begin
            inputRange <= ccp_range_type'(rangeSel);
            straightBinary <= codeSel;
            powerDown <= sleepSel;
        end
    end

    assign wordCommitted = committed_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_commit;
        committed_q;
    endsequence

    property p_commit_on_ninth;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_SHIFT && framed && lastEdge) |=> s_commit;
    endproperty
    a_commit_on_ninth: assert property (p_commit_on_ninth)
        else $error("ninth edge did not commit");

    property p_abort_keeps;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_SHIFT && !framed) |=> ($stable(word_q) && state_q == CCP_IDLE);
    endproperty
    a_abort_keeps: assert property (p_abort_keeps)
        else $error("aborted frame changed word");

    property p_reserved_stable;
        @(posedge clock) disable iff (!arst_n)
        1'b1 |=> (word_q[4:3] == $past(word_q[4:3]) && word_q[1:0] == $past(word_q[1:0]));
    endproperty
    a_reserved_stable: assert property (p_reserved_stable)
        else $error("reserved bits changed");

    property p_only_commit_changes;
        @(posedge clock) disable iff (!arst_n)
        !$stable(word_q) |-> committed_q;
    endproperty
    a_only_commit_changes: assert property (p_only_commit_changes)
        else $error("word changed without commit");

    property p_sw_range;
        @(posedge clock) disable iff (!arst_n)
        useSoftware |=> inputRange == ccp_range_type'($past(word_q[7:6]));
    endproperty
    a_sw_range: assert property (p_sw_range)
        else $error("range not from word");

    property p_hw_sleep;
        @(posedge clock) disable iff (!arst_n)
        useHardware |=> powerDown == $past(hwStage2_q[1]);
    endproperty
    a_hw_sleep: assert property (p_hw_sleep)
        else $error("sleep not from pin");

    property p_sw_code;
        @(posedge clock) disable iff (!arst_n)
        useSoftware |=> straightBinary == $past(word_q[CCP_CODE_POS]);
    endproperty
    a_sw_code: assert property (p_sw_code)
        else $error("coding not from word");

    property p_start_needed;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_IDLE && sampleEdge && !link.serialIn) |=> state_q == CCP_IDLE;
    endproperty
    a_start_needed: assert property (p_start_needed)
        else $error("frame began without start bit");

    property p_sw_sleep;
        @(posedge clock) disable iff (!arst_n)
        useSoftware |=> powerDown == $past(word_q[CCP_SLEEP_POS]);
    endproperty
    a_sw_sleep: assert property (p_sw_sleep)
        else $error("sleep not from word");

    sequence s_idle;
        state_q == CCP_IDLE;
    endsequence

    property p_select_release;
        @(posedge clock) disable iff (!arst_n)
        selectRise |=> s_idle;
    endproperty
    a_select_release: assert property (p_select_release)
        else $error("select release did not end frame");

    property p_abort_clears_count;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_SHIFT && !framed) |=> count_q == CCP_COUNT_RESET;
    endproperty
    a_abort_clears_count: assert property (p_abort_clears_count)
        else $error("aborted frame kept its count");

    property p_hw_range;
        @(posedge clock) disable iff (!arst_n)
        useHardware |=> inputRange == ccp_range_type'($past(hwStage2_q[3:2]));
    endproperty
    a_hw_range: assert property (p_hw_range)
        else $error("range not from pins");

    property p_hw_code;
        @(posedge clock) disable iff (!arst_n)
        useHardware |=> straightBinary == $past(hwStage2_q[0]);
    endproperty
    a_hw_code: assert property (p_hw_code)
        else $error("coding not from pin");

    property p_idle_unframed;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_IDLE && !framed) |=> s_idle;
    endproperty
    a_idle_unframed: assert property (p_idle_unframed)
        else $error("frame began outside serial software mode");

    property p_commit_pulse;
        @(posedge clock) disable iff (!arst_n)
        committed_q |=> !committed_q;
    endproperty
    a_commit_pulse: assert property (p_commit_pulse)
        else $error("commit pulse longer than one cycle");

    property p_done_holds;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_DONE && framed) |=> (state_q == CCP_DONE && $stable(word_q));
    endproperty
    a_done_holds: assert property (p_done_holds)
        else $error("edges after the ninth changed the word");

    property p_count_bound;
        @(posedge clock) disable iff (!arst_n)
        state_q == CCP_SHIFT |-> (count_q >= 4'h1 && count_q <= 4'h8);
    endproperty
    a_count_bound: assert property (p_count_bound)
        else $error("bit count out of range");

    property p_start_loads;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_IDLE && framed && sampleEdge && link.serialIn)
            |=> (state_q == CCP_SHIFT && shift_q[0] && count_q == 4'h1);
    endproperty
    a_start_loads: assert property (p_start_loads)
        else $error("start bit did not begin the load");

    property p_msb_first;
        @(posedge clock) disable iff (!arst_n)
        (state_q == CCP_SHIFT && framed && sampleEdge && !lastEdge)
            |=> (shift_q[0] == $past(link.serialIn) && shift_q[8:1] == $past(shift_q[7:0]));
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("shift order wrong");
endmodule : converter_config_port

// File: bench/ccp_host_model.sv
// Host model: frames and clocks words onto the serial configuration link.
// Assumes one caller at a time; idle link clock sits opposite its sampling edge.
`timescale 1ns/1ps
module ccp_host_model (
    // Edge choice
    input wire logic inv,
    // Link pins
    output logic selectN,
    output logic serialIn,
    output logic serialClock
);
    initial begin
        selectN = 1'b1;
        serialIn = 1'b0;
        serialClock = 1'b0;
    end
    // Short frames stop after the given edge count
    // No busy on this side, so a frame may start at any time
    task automatic send(input logic [8:0] w, input int edges);
        serialClock = inv;
        #80 selectN = 1'b0;
        #80;
        for (int i = 8; i > 8 - edges; i--) begin
            serialIn = w[i];
            #80 serialClock = ~inv;
            #80 serialClock = inv;
        end
        #80 selectN = 1'b1;
        // Released data line must not keep the last bit
        serialIn = ~serialIn;
    endtask : send
endmodule : ccp_host_model

// File: bench/tb.sv
// Testbench for the configuration port: pin straps and serial word writes.
// Assumes the host model drives the link; notes are checked on each commit pulse.
`timescale 1ns/1ps
module tb;
    import ccp_pkg::*;
    logic clock, arst_n, ifSel, srcSel, edgeInv, pinBip, pinWide, pinCode, pinSleep;
    logic selN, sIn, sClk, straightBinary, powerDown, wordCommitted;
    ccp_range_type inputRange;
    logic [3:0] expQ[$];
    logic [3:0] lastExp, note;
    int errTotal = 0;
    int nChecks = 0;
    int cycles = 0;
    wire logic [3:0] cfgNow = {inputRange, straightBinary, powerDown};

    converter_config_port i_converter_config_port (
        .clock(clock), .arst_n(arst_n), .interface_select(ifSel),
        .config_source_select(srcSel), .clock_edge_invert(edgeInv),
        .pinBipolar(pinBip), .wide_span_select(pinWide),
        .output_code_format(pinCode), .sleep_request(pinSleep),
        .cfg_select_n(selN), .cfg_serial_in(sIn), .cfg_serial_clock(sClk),
        .inputRange(inputRange), .straightBinary(straightBinary),
        .powerDown(powerDown), .wordCommitted(wordCommitted)
    );
    ccp_host_model i_ccp_host_model (
        .inv(edgeInv), .selectN(selN), .serialIn(sIn), .serialClock(sClk)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [3:0] seen, input logic [3:0] exp, input string what);
        nChecks++;
        if (seen !== exp) begin
            errTotal++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle
    task automatic write_word(input logic [8:0] w, input int edges, input bit takes);
        if (takes) begin
            lastExp = {w[7:6], w[2], w[5]};
            expQ.push_back(lastExp);
        end
        i_ccp_host_model.send(w, edges);
        settle(12);
        check({3'h0, expQ.size() != 0}, 4'h0, "commit missing");
        check(cfgNow, lastExp, "active word");
    endtask : write_word
    task automatic set_mode(input logic ser, input logic hw, input logic inv);
        ifSel = ser;
        srcSel = hw;
        edgeInv = inv;
        settle(6);
    endtask : set_mode
    task automatic pins_rand();
        {pinBip, pinWide, pinCode, pinSleep} = 4'($urandom);
        settle(6);
    endtask : pins_rand
    ////////////////////////////////////////////////////////////////////////
    // Commit pulse is sampled mid-cycle to avoid racing its own edge
    initial forever begin
        @(negedge clock);
        if (wordCommitted === 1'b1) begin
            if (expQ.size() == 0) begin
                check(4'h1, 4'h0, "unexpected commit");
            end else begin
                note = expQ.pop_front();
                @(negedge clock);
                check(cfgNow, note, "committed word");
            end
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            errTotal++;
            give_verdict();
        end
    end

    initial begin
        arst_n = 1'b0;
        {ifSel, srcSel, edgeInv} = 3'b100;
        {pinBip, pinWide, pinCode, pinSleep} = 4'h0;
        lastExp = 4'h0;
        void'($urandom(32'h014e581a));
        settle(3);
        check(cfgNow, 4'h0, "reset value");
        arst_n = 1'b1;
        settle(4);
        for (int inv = 0; inv < 2; inv++) begin
            set_mode(1'b1, 1'b0, 1'(inv));
            for (int r = 0; r < 4; r++) begin
                write_word({1'b1, 2'(r), 6'($urandom)}, 9, 1'b1);
            end
            write_word(9'h1E4, 9, 1'b1);
            write_word(9'h11B, 9, 1'b1);
        end
        $display("test serial writes done");
        write_word(9'h1FF, 5, 1'b0);
        write_word(9'h0E4, 9, 1'b0);
        $display("test refused frames done");
        for (int m = 0; m < 2; m++) begin
            set_mode(1'(m), 1'(m), 1'b0);
            repeat (4) begin
                pins_rand();
                check(cfgNow, {pinBip, pinWide, pinCode, pinSleep}, "pin mode");
            end
            i_ccp_host_model.send(9'h1E4, 9);
            settle(12);
            check(cfgNow, {pinBip, pinWide, pinCode, pinSleep}, "frame in pin mode");
        end
        $display("test pin modes done");
        set_mode(1'b1, 1'b0, 1'b0);
        write_word(9'h1E4, 9, 1'b1);
        repeat (3) begin
            pins_rand();
            check(cfgNow, lastExp, "pins ignored");
        end
        arst_n = 1'b0;
        settle(2);
        check(cfgNow, 4'h0, "second reset");
        arst_n = 1'b1;
        lastExp = 4'h0;
        settle(4);
        write_word(9'h1A4, 9, 1'b1);
        $display("test software mode done");
        give_verdict();
    end
endmodule : tb
